/* File: core/tx_char_path.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_char_path #(
  parameter int BIT_DIV = tx_codec_pkg::BIT_DIV
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire tx_codec_pkg::bus_req_t i_bus,
  output logic [31:0] o_rdata,
  input wire tx_codec_pkg::tx_char_t i_tx,
  input wire logic i_pab_fault,
  output logic o_phase_align_error,
  output logic o_ser_data,
  output logic [9:0] o_tx_char,
  output logic o_char_rate_clock_out,
  output logic o_ref_tick,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] sts;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic [3:0] div;
    logic [3:0] bitcnt;
    logic [9:0] shift;
    logic [9:0] last_char;
    logic ser;
    logic cro;
    logic ref_tick;
    logic half;
    logic pab_err;
    logic ws_active;
    logic [3:0] ws_cnt;
    logic [8:0] lfsr;
    logic pre_done;
  } st_t;
  st_t q, d;

  localparam logic [3:0] DIV_LAST = 4'(BIT_DIV - 1);

  // ----------------------------------------------------------------
  // Special character tables
  // ----------------------------------------------------------------
  // Returns {violation, K byte}; several codes share K28.5
  function automatic logic [8:0] spec_map(input logic [3:0] c);
    case (c)
      4'h8: spec_map = {1'b0, 3'h7, 5'd23};
      4'h9: spec_map = {1'b0, 3'h7, 5'd27};
      4'hA: spec_map = {1'b0, 3'h7, 5'd29};
      4'hB: spec_map = {1'b0, 3'h7, 5'd30};
      4'hC: spec_map = {1'b1, 8'h00};
      4'hD, 4'hE, 4'hF: spec_map = {1'b0, tx_codec_pkg::K28_5};
      default: spec_map = {1'b0, c[2:0], 5'd28};
    endcase
  endfunction

  // Table base chosen by control; codes off the table are violations
  function automatic logic [8:0] spec_lookup(input logic tbl,
                                             input logic [7:0] code);
    logic [7:0] base;
    base = tbl ? tx_codec_pkg::SPEC_TBL1_BASE : tx_codec_pkg::SPEC_TBL0_BASE;
    if (code[7:4] == base[7:4]) begin
      spec_lookup = spec_map(code[3:0]);
    end else begin
      spec_lookup = {1'b1, 8'h00};
    end
  endfunction

  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  logic enc_load;
  logic enc_k;
  logic [7:0] enc_data;
  logic [9:0] enc_code;
  logic enc_rd;

  tx_enc8b10b u_enc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(enc_load),
    .i_k(enc_k),
    .i_data(enc_data),
    .o_code(enc_code),
    .o_rd_pos(enc_rd)
  );

  // ----------------------------------------------------------------
  // Character selection
  // ----------------------------------------------------------------
  logic bit_en;
  logic char_en;
  logic enc_en;
  logic bist_on;
  logic use_enc;
  logic viol;
  logic raw;
  logic [9:0] raw_char;
  logic ws_start;
  logic ws_end;
  logic lfsr_step;
  logic [8:0] lfsr_nx;
  logic [8:0] spec;

  // Priority: sync in flight, self-test, host sync request, error, host character
  always_comb begin
    enc_en = q.ctrl[tx_codec_pkg::CTRL_ENC_EN];
    bist_on = q.ctrl[tx_codec_pkg::CTRL_SELFTEST];
    use_enc = 1'b1;
    viol = 1'b0;
    raw = 1'b0;
    raw_char = {i_tx.ctl, i_tx.chr};
    enc_k = 1'b1;
    enc_data = tx_codec_pkg::K28_5;
    ws_start = 1'b0;
    ws_end = 1'b0;
    lfsr_step = 1'b0;
    lfsr_nx = {q.lfsr[7:0], q.lfsr[8] ^ q.lfsr[4]};
    spec = spec_lookup(q.ctrl[tx_codec_pkg::CTRL_SPEC_TBL], i_tx.chr);
    if (q.ws_active) begin
      // Inputs are ignored; K28.5 continues to the sixteenth
      ws_end = (q.ws_cnt == tx_codec_pkg::WS_LAST);
    end else if (bist_on) begin
      // Host inputs play no part in self-test
      if (q.ctrl[tx_codec_pkg::CTRL_REFMODE] && !q.pre_done) begin
        ws_start = 1'b1;
      end else if (q.pab_err) begin
        viol = 1'b1;
      end else begin
        lfsr_step = 1'b1;
        if (q.lfsr[8]) begin
          spec = spec_map(q.lfsr[3:0]);
          viol = spec[8];
          enc_data = spec[7:0];
        end else begin
          enc_k = 1'b0;
          enc_data = q.lfsr[7:0];
        end
      end
    end else if (enc_en && i_tx.ctl == tx_codec_pkg::CT_SYNC) begin
      ws_start = 1'b1;
    end else if (q.pab_err) begin
      viol = 1'b1;
    end else if (!enc_en) begin
      raw = 1'b1;
    end else begin
      case (i_tx.ctl)
        tx_codec_pkg::CT_DATA: begin
          enc_k = 1'b0;
          enc_data = i_tx.chr;
        end
        tx_codec_pkg::CT_FILL: begin
          enc_data = tx_codec_pkg::K28_5;
        end
        tx_codec_pkg::CT_SPECIAL: begin
          viol = spec[8];
          enc_data = spec[7:0];
        end
        default: begin
          enc_data = tx_codec_pkg::K28_5;
        end
      endcase
    end
    if (viol || raw) begin
      use_enc = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [9:0] next_char;
  logic [2:0] sts_set;
  always_comb begin
    d = q;
    sts_set = '0;
    // Bit and character enables from the one system clock
    bit_en = (q.div == DIV_LAST);
    d.div = bit_en ? 4'h0 : q.div + 4'h1;
    char_en = bit_en && (q.bitcnt == tx_codec_pkg::BIT_LAST);
    enc_load = char_en && use_enc;
    next_char = viol ? tx_codec_pkg::VIOL_C07 : (raw ? raw_char : enc_code);
    d.cro = char_en;
    d.ref_tick = 1'b0;
    // Serial shifter: bit 0 of each character goes out first
    if (bit_en) begin
      if (char_en) begin
        d.bitcnt = 4'h0;
        d.ser = next_char[0];
        d.shift = {1'b0, next_char[9:1]};
        d.last_char = next_char;
        // Half-rate reference spans two characters
        d.half = ~q.half;
        d.ref_tick = !q.ctrl[tx_codec_pkg::CTRL_RATE] || q.half;
      end else begin
        d.bitcnt = q.bitcnt + 4'h1;
        d.ser = q.shift[0];
        d.shift = {1'b0, q.shift[9:1]};
      end
    end
    // Word sync sequencing, counted in characters sent
    if (char_en) begin
      if (ws_start) begin
        d.ws_active = 1'b1;
        d.ws_cnt = 4'h1;
        if (bist_on) begin
          d.pre_done = 1'b1;
        end else begin
          d.pab_err = 1'b0;
        end
      end else if (q.ws_active) begin
        if (ws_end) begin
          d.ws_active = 1'b0;
          d.ws_cnt = 4'h0;
          sts_set[tx_codec_pkg::IRQ_WS_DONE] = 1'b1;
        end else begin
          d.ws_cnt = q.ws_cnt + 4'h1;
        end
      end
      if (lfsr_step) begin
        d.lfsr = lfsr_nx;
        if (lfsr_nx == tx_codec_pkg::LFSR_SEED) begin
          d.pre_done = 1'b0;
          sts_set[tx_codec_pkg::IRQ_PASS_DONE] = 1'b1;
        end
      end
    end
    // Pattern restarts from the seed whenever self-test is off
    if (!bist_on) begin
      d.lfsr = tx_codec_pkg::LFSR_SEED;
      d.pre_done = 1'b0;
    end
    // Register writes
    d.rdata = 32'h0000_0000;
    if (i_bus.wr) begin
      case (i_bus.addr)
        tx_codec_pkg::CTRL_ADDR: begin
          d.ctrl = i_bus.wdata[7:0];
          if (!i_bus.wdata[tx_codec_pkg::CTRL_PAB_RST]) begin
            d.pab_err = 1'b0;
          end
        end
        tx_codec_pkg::IRQ_STS_ADDR: begin
          d.sts = q.sts & ~i_bus.wdata[2:0];
        end
        tx_codec_pkg::IRQ_MASK_ADDR: begin
          d.mask = i_bus.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // Reads answer one cycle later; unmapped reads give zero
    if (i_bus.rd) begin
      case (i_bus.addr)
        tx_codec_pkg::CTRL_ADDR: begin
          d.rdata = {24'h00_0000, q.ctrl};
        end
        tx_codec_pkg::IRQ_STS_ADDR: begin
          d.rdata = {29'h0000_0000, q.sts};
        end
        tx_codec_pkg::IRQ_MASK_ADDR: begin
          d.rdata = {29'h0000_0000, q.mask};
        end
        tx_codec_pkg::STATE_ADDR: begin
          d.rdata = {16'h0000, 4'h0, q.ws_cnt, 2'h0, enc_rd,
                     q.pre_done, q.ws_active, bist_on, q.pab_err,
                     q.ctrl[6:5] == tx_codec_pkg::SPD_LOW
                     && q.ctrl[tx_codec_pkg::CTRL_RATE]};
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
    // Buffer fault latches the error; a fault beats a clear
    if (i_pab_fault) begin
      d.pab_err = 1'b1;
      sts_set[tx_codec_pkg::IRQ_PAB_ERR] = 1'b1;
    end
    d.sts = d.sts | sts_set;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset clears self-test and leaves the encoder enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.ctrl <= tx_codec_pkg::CTRL_RST;
      q.lfsr <= tx_codec_pkg::LFSR_SEED;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = q.rdata;
  assign o_phase_align_error = q.pab_err;
  assign o_ser_data = q.ser;
  assign o_tx_char = q.last_char;
  assign o_char_rate_clock_out = q.cro;
  assign o_ref_tick = q.ref_tick;
  assign o_irq = |(q.sts & q.mask);
endmodule
`default_nettype wire

/* File: core/tx_codec_pkg.sv */
`default_nettype none
package tx_codec_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] IRQ_STS_ADDR = 4'h4;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'h8;
  localparam logic [3:0] STATE_ADDR = 4'hC;
  localparam int CTRL_ENC_EN = 0;
  localparam int CTRL_SELFTEST = 1;
  localparam int CTRL_RATE = 2;
  localparam int CTRL_PAB_RST = 3;
  localparam int CTRL_REFMODE = 4;
  localparam int CTRL_SPD_LO = 5;
  localparam int CTRL_SPEC_TBL = 7;
  localparam logic [7:0] CTRL_RST = 8'h09;
  localparam int IRQ_PAB_ERR = 0;
  localparam int IRQ_WS_DONE = 1;
  localparam int IRQ_PASS_DONE = 2;
  localparam logic [1:0] SPD_LOW = 2'h0;
  // ----------------------------------------------------------------
  // Character constants and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] CT_DATA = 2'h0;
  localparam logic [1:0] CT_FILL = 2'h1;
  localparam logic [1:0] CT_SPECIAL = 2'h2;
  localparam logic [1:0] CT_SYNC = 2'h3;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [9:0] VIOL_C07 = 10'h1E7;
  localparam logic [3:0] WS_LAST = 4'hF;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;
  localparam logic [7:0] SPEC_TBL0_BASE = 8'h00;
  localparam logic [7:0] SPEC_TBL1_BASE = 8'h20;
  localparam int CLK_HZ = 50000000;
  localparam int BIT_DIV = 2;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic [1:0] ctl;
    logic [7:0] chr;
  } tx_char_t;
endpackage
`default_nettype wire

/* File: core/tx_enc8b10b.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_enc8b10b (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_k,
  input wire logic [7:0] i_data,
  output logic [9:0] o_code,
  output logic o_rd_pos
);
  typedef struct packed {
    logic rd;
  } enc_st_t;
  enc_st_t q, d;

  // ----------------------------------------------------------------
  // Code tables, written abcdei / fghj with a leftmost
  // ----------------------------------------------------------------
  function automatic logic [5:0] tbl6(input logic [4:0] x);
    logic [191:0] t;
    t = {6'h2B, 6'h1E, 6'h16, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26,
         6'h33, 6'h3A, 6'h1A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
         6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
         6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
    tbl6 = t[x*6 +: 6];
  endfunction

  function automatic logic [3:0] tbl4(input logic [2:0] y);
    logic [31:0] t;
    t = {4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
    tbl4 = t[y*4 +: 4];
  endfunction

  function automatic int ones(input logic [5:0] v);
    ones = 0;
    for (int i = 0; i < 6; i++) begin
      ones = ones + int'(v[i]);
    end
  endfunction

  // ----------------------------------------------------------------
  // Encode against current disparity; commit on load
  // ----------------------------------------------------------------
  logic [5:0] c6;
  logic [3:0] c4;
  logic rd_mid;
  logic alt7;
  always_comb begin
    d = q;
    c6 = tbl6(i_data[4:0]);
    if (i_k && i_data[4:0] == 5'h1C) begin
      c6 = 6'h0F;
    end
    if (i_data[4:0] == 5'h07) begin
      c6 = q.rd ? 6'h07 : 6'h38;
    end else if (q.rd && ones(c6) != 3) begin
      c6 = ~c6;
    end
    rd_mid = (ones(c6) != 3) ? ~q.rd : q.rd;
    alt7 = i_k || (!rd_mid && (i_data[4:0] == 5'd17 || i_data[4:0] == 5'd18
           || i_data[4:0] == 5'd20)) || (rd_mid && (i_data[4:0] == 5'd11
           || i_data[4:0] == 5'd13 || i_data[4:0] == 5'd14));
    c4 = (i_data[7:5] == 3'h7 && alt7) ? 4'h7 : tbl4(i_data[7:5]);
    // Balanced K groups flip on the opposite sense from data groups
    if (i_k && ones({2'b00, c4}) == 2 && c4 != 4'hC) begin
      if (!rd_mid) begin
        c4 = ~c4;
      end
    end else if (rd_mid && (ones({2'b00, c4}) != 2 || c4 == 4'hC)) begin
      c4 = ~c4;
    end
    if (i_load) begin
      d.rd = (ones({2'b00, c4}) != 2) ? ~rd_mid : rd_mid;
    end
    // Bit 0 carries a so the shifter sends a first
    for (int i = 0; i < 6; i++) begin
      o_code[i] = c6[5-i];
    end
    for (int i = 0; i < 4; i++) begin
      o_code[6+i] = c4[3-i];
    end
  end

  assign o_rd_pos = q.rd;

  // Disparity starts negative
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tx_char_path_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_char_path_props #(
  parameter int BIT_DIV = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire tx_codec_pkg::bus_req_t i_bus,
  input wire logic [31:0] o_rdata,
  input wire tx_codec_pkg::tx_char_t i_tx,
  input wire logic i_pab_fault,
  input wire logic o_phase_align_error,
  input wire logic o_ser_data,
  input wire logic [9:0] o_tx_char,
  input wire logic o_char_rate_clock_out,
  input wire logic o_ref_tick,
  input wire logic o_irq
);
  // --------
  // Shadow of control bits
  // --------
  logic enc_q, st_q, msk_q, seen_q, rate_q;
  logic [7:0] pos_q;
  wire is_k = o_tx_char == 10'h17C || o_tx_char == 10'h283;
  // Mirror writes so the checks know the mode without seeing inside
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enc_q <= 1'b1;
      st_q <= 1'b0;
      rate_q <= 1'b0;
      msk_q <= 1'b0;
      seen_q <= 1'b0;
      pos_q <= 8'h0;
    end else begin
      if (i_bus.wr && i_bus.addr == tx_codec_pkg::CTRL_ADDR) begin
        enc_q <= i_bus.wdata[0];
        st_q <= i_bus.wdata[1];
        rate_q <= i_bus.wdata[2];
      end
      if (i_bus.wr && i_bus.addr == tx_codec_pkg::IRQ_MASK_ADDR) begin
        msk_q <= i_bus.wdata[0];
      end
      seen_q <= seen_q | o_char_rate_clock_out;
      pos_q <= o_char_rate_clock_out ? 8'h1 : pos_q + 8'h1;
    end
  end
  // --------
  // Properties
  // --------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_err_set;
    i_pab_fault && !i_bus.wr |=> o_phase_align_error;
  endproperty
  a_err_set: assert property (p_err_set) else $error("fault not latched");
  property p_err_hold;
    o_phase_align_error && !i_bus.wr |=> o_phase_align_error || o_char_rate_clock_out;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped");
  property p_viol;
    o_char_rate_clock_out && o_phase_align_error && $past(o_phase_align_error)
      |-> o_tx_char == tx_codec_pkg::VIOL_C07;
  endproperty
  a_viol: assert property (p_viol) else $error("no violation char");
  property p_period;
    o_char_rate_clock_out && seen_q |-> pos_q == 8'(10 * BIT_DIV);
  endproperty
  a_period: assert property (p_period) else $error("bad char period");
  // Bit index wraps at the pulse so bit a lines up with the load
  property p_ser;
    seen_q |-> o_ser_data == o_tx_char[(pos_q % (10 * BIT_DIV)) / BIT_DIV];
  endproperty
  a_ser: assert property (p_ser) else $error("serial order wrong");
  property p_stable;
    !o_char_rate_clock_out |-> $stable(o_tx_char);
  endproperty
  a_stable: assert property (p_stable) else $error("char moved");
  property p_byp;
    o_char_rate_clock_out && $past(!enc_q && !st_q) && !$past(o_phase_align_error)
      |-> o_tx_char == $past(i_tx);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass altered");
  property p_kset;
    o_char_rate_clock_out && $past(enc_q && !st_q && i_tx.ctl[0])
      && !$past(o_phase_align_error) |-> is_k;
  endproperty
  a_kset: assert property (p_kset) else $error("not K28.5");
  property p_irq;
    i_pab_fault && msk_q |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  // Reference tick only ever rides on a character pulse
  property p_ref_char;
    o_ref_tick |-> o_char_rate_clock_out;
  endproperty
  a_ref_char: assert property (p_ref_char) else $error("ref tick off char");
  property p_ref_full;
    o_char_rate_clock_out && !$past(rate_q) |-> o_ref_tick;
  endproperty
  a_ref_full: assert property (p_ref_full) else $error("ref tick missing");
  c_viol: cover property (o_char_rate_clock_out && o_tx_char == tx_codec_pkg::VIOL_C07);
  c_fill: cover property (o_char_rate_clock_out && is_k);
  c_byp: cover property (o_char_rate_clock_out && !enc_q);
endmodule
bind tx_char_path tx_char_path_props #(.BIT_DIV(BIT_DIV)) props (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_tx(i_tx),
  .i_pab_fault(i_pab_fault), .o_phase_align_error(o_phase_align_error),
  .o_ser_data(o_ser_data), .o_tx_char(o_tx_char),
  .o_char_rate_clock_out(o_char_rate_clock_out), .o_ref_tick(o_ref_tick), .o_irq(o_irq));
`default_nettype wire

/* File: bench/host_char_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_char_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_char_tick,
  input wire tx_codec_pkg::tx_char_t i_next,
  output var tx_codec_pkg::tx_char_t o_tx
);
  // --------
  // Host side
  // --------
  // New character just after each char pulse, held a full period
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_tx <= '0;
    end else if (i_char_tick) begin
      o_tx <= i_next;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int BD = 1;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic fault = 1'b0;
  tx_codec_pkg::bus_req_t bus = '0;
  tx_codec_pkg::tx_char_t nxt = '0;
  tx_codec_pkg::tx_char_t tx;
  logic [31:0] rdata;
  logic err, ser, cro, irq, rtick;
  logic [9:0] txc, got;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  tx_char_path #(.BIT_DIV(BD)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus),
    .o_rdata(rdata), .i_tx(tx), .i_pab_fault(fault), .o_phase_align_error(err),
    .o_ser_data(ser), .o_tx_char(txc), .o_char_rate_clock_out(cro), .o_ref_tick(rtick),
    .o_irq(irq));
  host_char_model host (.i_clk(i_clk), .i_rst(i_rst), .i_char_tick(cro),
    .i_next(nxt), .o_tx(tx));
  always #10 i_clk = ~i_clk;
  // Hang guard, well above the two self-test runs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      give_verdict();
    end
  end
  // --------
  // Helpers
  // --------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge i_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    bus <= {1'b0, 1'b1, a, 32'h0};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
    d = rdata;
  endtask
  // Output seen here is from the input given two calls earlier
  task automatic step(input logic [1:0] c, input logic [7:0] d);
    @(posedge i_clk iff cro);
    got = txc;
    nxt <= {c, d};
  endtask
  function automatic logic is_k(input logic [9:0] c);
    return c === 10'h17C || c === 10'h283;
  endfunction
  task automatic pulse_fault();
    @(posedge i_clk);
    fault <= 1'b1;
    @(posedge i_clk);
    fault <= 1'b0;
    @(posedge i_clk);
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_regs();
    logic [31:0] d;
    rd(tx_codec_pkg::CTRL_ADDR, d);
    chk("ctrl reset", 32'h9, d);
    rd(tx_codec_pkg::STATE_ADDR, d);
    chk("selftest off", 32'h0, 32'(d[2]));
    rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    $display("register test done");
  endtask
  task automatic t_fill();
    logic [9:0] prev;
    prev = '0;
    for (int i = 0; i < 6; i++) begin
      step(2'h1, 8'h00);
      chk("ref tick", 32'h1, 32'(rtick));
      if (i >= 2) chk("fill", 32'h1, 32'(is_k(got)));
      if (i >= 3) chk("disparity", 32'(prev ^ 10'h3FF), 32'(got));
      prev = got;
    end
    $display("fill test done");
  endtask
  // Sync asked for hold periods, then plain data meant to be ignored
  task automatic t_sync(input int hold, input int exp_run);
    int run;
    logic [31:0] d;
    run = 0;
    for (int i = 0; i < hold + 40; i++) begin
      step(i < hold ? 2'h3 : 2'h0, 8'h55);
      if (i >= 2 && is_k(got)) run++;
    end
    chk("sync run", 32'(exp_run), 32'(run));
    rd(tx_codec_pkg::IRQ_STS_ADDR, d);
    chk("sync done flag", 32'h1, 32'(d[1]));
    wr(tx_codec_pkg::IRQ_STS_ADDR, 32'h2);
    $display("sync test done");
  endtask
  task automatic t_bypass();
    logic [9:0] v [2];
    v[0] = 10'h25A;
    v[1] = 10'h1C3;
    wr(tx_codec_pkg::CTRL_ADDR, 32'h28);
    for (int i = 0; i < 6; i++) begin
      step(v[i % 2][9:8], v[i % 2][7:0]);
      if (i >= 2) chk("raw char", 32'(v[i % 2]), 32'(got));
      for (int k = 1; i == 5 && k < 10; k++) begin
        repeat (BD) @(posedge i_clk);
        chk("serial bit", 32'(got[k]), 32'(ser));
      end
    end
    $display("bypass test done");
  endtask
  // Half-rate reference: tick on every other character
  task automatic t_rate();
    logic prev;
    prev = 1'b0;
    wr(tx_codec_pkg::CTRL_ADDR, 32'h2D);
    for (int i = 0; i < 8; i++) begin
      step(2'h1, 8'h00);
      if (i >= 1) chk("ref tick", 32'(!prev), 32'(rtick));
      prev = rtick;
    end
    $display("rate test done");
  endtask
  // Second table: two codes share K28.5, a first-table code is refused
  task automatic t_special();
    logic [7:0] c;
    wr(tx_codec_pkg::CTRL_ADDR, 32'hA9);
    for (int i = 0; i < 6; i++) begin
      c = (i % 2 == 1) ? 8'h0D : ((i % 4 == 0) ? 8'h2D : 8'h2E);
      step(2'h2, c);
      if (i >= 2 && i % 2 == 0) chk("table code", 32'h1, 32'(is_k(got)));
      if (i >= 2 && i % 2 == 1) chk("off table", 32'(tx_codec_pkg::VIOL_C07), 32'(got));
    end
    $display("special test done");
  endtask
  task automatic t_error();
    logic [31:0] d;
    pulse_fault();
    chk("error flag", 32'h1, 32'(err));
    for (int i = 0; i < 5; i++) begin
      step(2'h0, 8'h12);
      if (i >= 2) chk("violation", 32'(tx_codec_pkg::VIOL_C07), 32'(got));
    end
    chk("irq masked", 32'h0, 32'(irq));
    wr(tx_codec_pkg::IRQ_MASK_ADDR, 32'h1);
    @(posedge i_clk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(tx_codec_pkg::IRQ_STS_ADDR, 32'h1);
    @(posedge i_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    pulse_fault();
    chk("irq again", 32'h1, 32'(irq));
    wr(tx_codec_pkg::IRQ_STS_ADDR, 32'h1);
    rd(tx_codec_pkg::IRQ_STS_ADDR, d);
    chk("status cleared", 32'h0, 32'(d[0]));
    step(2'h0, 8'h12);
    chk("still violation", 32'(tx_codec_pkg::VIOL_C07), 32'(got));
    chk("error held", 32'h1, 32'(err));
    for (int i = 0; i < 20; i++) begin
      step(i == 0 ? 2'h3 : 2'h0, 8'h12);
    end
    chk("error cleared", 32'h0, 32'(err));
    $display("error test done");
  endtask
  // Second pass length is timed between two pass-end interrupts
  task automatic t_selftest(input logic [31:0] ctrl, input int exp_len);
    int n;
    wr(tx_codec_pkg::IRQ_MASK_ADDR, 32'h4);
    wr(tx_codec_pkg::CTRL_ADDR, ctrl);
    for (int p = 0; p < 2; p++) begin
      n = 0;
      wr(tx_codec_pkg::IRQ_STS_ADDR, 32'h4);
      @(posedge i_clk);
      while (irq !== 1'b1 && n < 1200) begin
        step(2'h3, 8'hFF);
        n++;
      end
    end
    chk("pass length", 32'(exp_len), 32'(n));
    $display("selftest test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_fill();
    t_sync(1, 16);
    t_sync(17, 32);
    t_bypass();
    t_rate();
    t_special();
    wr(tx_codec_pkg::CTRL_ADDR, 32'h29);
    t_error();
    t_selftest(32'h2B, 511);
    t_selftest(32'h3B, 527);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    give_verdict();
  end
endmodule
`default_nettype wire
